//--- design/eag_alu.v
`timescale 1ns/10ps
`include "eag_consts.vh"

module eag_alu (
    input wire [2:0] op_i,
    input wire [31:0] a_i,
    input wire [31:0] b_i,
    input wire extend_i,
    output reg [31:0] res_o,
    output reg trap_o
);

reg [31:0] sa;
reg [31:0] sb;
reg [15:0] quot;
reg [15:0] rem;
reg [4:0] lo;
reg [4:0] hi;
reg [3:0] qv;

always @* begin
    sa = 32'h0000_0000;
    sb = 32'h0000_0000;
    quot = 16'h0000;
    rem = 16'h0000;
    lo = 5'h00;
    hi = 5'h00;
    qv = {1'b0, b_i[2:0]};
    res_o = 32'h0000_0000;
    trap_o = 1'b0;
    if (qv == 4'h0) begin
        // a quick count of zero stands for eight
        qv = 4'h8;
    end
    case (op_i)
        `EAG_ALU_MULU: begin
            res_o = {16'h0000, a_i[15:0]} * {16'h0000, b_i[15:0]};
        end
        `EAG_ALU_MULS: begin
            sa = {{16{a_i[15]}}, a_i[15:0]};
            sb = {{16{b_i[15]}}, b_i[15:0]};
            res_o = $signed(sa) * $signed(sb);
        end
        `EAG_ALU_DIVU: begin
            if (b_i[15:0] == 16'h0000) begin
                trap_o = 1'b1;
            end else begin
                sa = a_i / {16'h0000, b_i[15:0]};
                sb = a_i % {16'h0000, b_i[15:0]};
                quot = sa[15:0];
                rem = sb[15:0];
                res_o = {rem, quot};
            end
        end
        `EAG_ALU_DIVS: begin
            if (b_i[15:0] == 16'h0000) begin
                trap_o = 1'b1;
            end else begin
                sb = {{16{b_i[15]}}, b_i[15:0]};
                sa = $signed(a_i) / $signed(sb);
                quot = sa[15:0];
                sa = $signed(a_i) % $signed(sb);
                rem = sa[15:0];
                res_o = {rem, quot};
            end
        end
        `EAG_ALU_ABCD: begin
            lo = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, extend_i};
            if (lo > 5'h09) begin
                lo = lo + 5'h06;
            end
            hi = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, lo[4]};
            if (hi > 5'h09) begin
                hi = hi + 5'h06;
            end
            res_o = {23'h00_0000, hi[4], hi[3:0], lo[3:0]};
        end
        `EAG_ALU_SBCD: begin
            lo = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, extend_i};
            if (lo[4]) begin
                lo = lo - 5'h06;
            end
            hi = {1'b0, a_i[7:4]} - {1'b0, b_i[7:4]} - {4'h0, lo[4]};
            if (hi[4]) begin
                hi = hi - 5'h06;
            end
            res_o = {23'h00_0000, hi[4], hi[3:0], lo[3:0]};
        end
        `EAG_ALU_ADDQ: begin
            res_o = a_i + {28'h000_0000, qv};
        end
        `EAG_ALU_SUBQ: begin
            res_o = a_i - {28'h000_0000, qv};
        end
        default: begin
            res_o = 32'h0000_0000;
        end
    endcase
end

endmodule // eag_alu

//--- design/eag_consts.vh
`ifndef EAG_CONSTS_VH
`define EAG_CONSTS_VH

// addressing mode codes on MODE_I
`define EAG_MODE_DREG 4'h0
`define EAG_MODE_AREG 4'h1
`define EAG_MODE_IND 4'h2
`define EAG_MODE_POSTINC 4'h3
`define EAG_MODE_PREDEC 4'h4
`define EAG_MODE_DISP 4'h5
`define EAG_MODE_INDEX 4'h6
`define EAG_MODE_ABS_SHORT 4'h7
`define EAG_MODE_ABS_LONG 4'h8
`define EAG_MODE_PC_DISP 4'h9
`define EAG_MODE_PC_INDEX 4'hA
`define EAG_MODE_IMM 4'hB
`define EAG_MODE_QUICK 4'hC
`define EAG_MODE_IMPLIED 4'hD

// operand size codes on SIZE_I
`define EAG_SIZE_BYTE 2'h0
`define EAG_SIZE_WORD 2'h1
`define EAG_SIZE_LONG 2'h2

// auto step amounts
`define EAG_STEP_BYTE 32'h0000_0001
`define EAG_STEP_WORD 32'h0000_0002
`define EAG_STEP_LONG 32'h0000_0004
`define EAG_STEP_SP_BYTE 32'h0000_0002

// register number of the stack pointer
`define EAG_SP_NUM 3'h7

// implied register select codes
`define EAG_IMPL_STATUS 2'h0
`define EAG_IMPL_USP 2'h1
`define EAG_IMPL_SSP 2'h2
`define EAG_IMPL_PC 2'h3

// arithmetic operation codes on ALU_OP_I
`define EAG_ALU_MULU 3'h0
`define EAG_ALU_MULS 3'h1
`define EAG_ALU_DIVU 3'h2
`define EAG_ALU_DIVS 3'h3
`define EAG_ALU_ABCD 3'h4
`define EAG_ALU_SBCD 3'h5
`define EAG_ALU_ADDQ 3'h6
`define EAG_ALU_SUBQ 3'h7

`endif

//--- design/eag_core.v
`timescale 1ns/10ps
`include "eag_consts.vh"

module eag_core (
    input wire MCLK_I,
    input wire RST_N_I,
    input wire REQ_I,
    input wire [3:0] MODE_I,
    input wire [1:0] SIZE_I,
    input wire [2:0] REG_SEL_I,
    input wire [31:0] DATA_REG_I,
    input wire [31:0] ADDR_REG_I,
    input wire [31:0] IDX_DATA_I,
    input wire [31:0] IDX_ADDR_I,
    input wire IDX_IS_ADDR_I,
    input wire IDX_LONG_I,
    input wire [15:0] EXT0_I,
    input wire [15:0] EXT1_I,
    input wire [7:0] QUICK_I,
    input wire [1:0] IMPL_SEL_I,
    input wire [31:0] PROG_COUNTER_I,
    input wire [15:0] STATUS_REG_I,
    input wire [31:0] USER_STACK_PTR_I,
    input wire [31:0] SUPERVISOR_STACK_PTR_I,
    input wire [2:0] ALU_OP_I,
    input wire [31:0] ALU_A_I,
    input wire [31:0] ALU_B_I,
    input wire ALU_X_I,
    output reg DONE_O,
    output reg ERR_O,
    output reg MEM_ACCESS_O,
    output reg [31:0] EFF_ADDR_O,
    output reg [31:0] OPERAND_O,
    output reg [3:0] BYTE_LANES_O,
    output reg WB_EN_O,
    output reg [2:0] WB_REG_O,
    output reg [31:0] WB_VALUE_O,
    output reg [31:0] ALU_RESULT_O,
    output reg ALU_TRAP_O
);

reg rst_meta;
reg rst_sync;
reg next_err;
reg next_mem;
reg [31:0] next_eff_addr;
reg [31:0] next_operand;
reg [3:0] next_lanes;
reg next_wb_en;
reg [31:0] next_wb_value;
reg [31:0] step;
reg size_ok;
reg [2:0] mode_family;
wire [31:0] disp16;
wire [31:0] disp8;
wire [31:0] index_raw;
wire [31:0] index_reg;
wire [31:0] abs_short;
wire [31:0] abs_long;
wire [31:0] quick_val;
wire [31:0] alu_res;
wire alu_trap;

// six mode families; spare code 7 marks a refused mode
localparam [2:0] fam_direct = 3'h0;
localparam [2:0] fam_indirect = 3'h1;
localparam [2:0] fam_absolute = 3'h2;
localparam [2:0] fam_immediate = 3'h3;
localparam [2:0] fam_pc_rel = 3'h4;
localparam [2:0] fam_implied = 3'h5;
localparam [2:0] fam_none = 3'h7;

// reset is asserted at once but released through two flops
always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        rst_meta <= 1'b0;
        rst_sync <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_sync <= rst_meta;
    end
end

// displacements are sign extended to the full address width
assign disp16 = {{16{EXT0_I[15]}}, EXT0_I};
assign disp8 = {{24{EXT0_I[7]}}, EXT0_I[7:0]};

// index comes from either register bank, word or long
assign index_raw = IDX_IS_ADDR_I ? IDX_ADDR_I : IDX_DATA_I;
assign index_reg = IDX_LONG_I ? index_raw :
    {{16{index_raw[15]}}, index_raw[15:0]};

assign abs_short = {{16{EXT0_I[15]}}, EXT0_I};
assign abs_long = {EXT0_I, EXT1_I};
assign quick_val = {{24{QUICK_I[7]}}, QUICK_I};

// step size, widened for bytes on the stack pointer
always @* begin
    step = `EAG_STEP_BYTE;
    size_ok = 1'b1;
    case (SIZE_I)
        `EAG_SIZE_BYTE: begin
            if (REG_SEL_I == `EAG_SP_NUM) begin
                step = `EAG_STEP_SP_BYTE;
            end else begin
                step = `EAG_STEP_BYTE;
            end
        end
        `EAG_SIZE_WORD: begin
            step = `EAG_STEP_WORD;
        end
        `EAG_SIZE_LONG: begin
            step = `EAG_STEP_LONG;
        end
        default: begin
            // the spare size code is refused for every mode
            size_ok = 1'b0;
        end
    endcase
end

// family decode; a code outside the six families is refused
always @* begin
    mode_family = fam_none;
    case (MODE_I)
        `EAG_MODE_DREG, `EAG_MODE_AREG: begin
            mode_family = fam_direct;
        end
        `EAG_MODE_IND, `EAG_MODE_POSTINC, `EAG_MODE_PREDEC, `EAG_MODE_DISP,
        `EAG_MODE_INDEX: begin
            mode_family = fam_indirect;
        end
        `EAG_MODE_ABS_SHORT, `EAG_MODE_ABS_LONG: begin
            mode_family = fam_absolute;
        end
        `EAG_MODE_IMM, `EAG_MODE_QUICK: begin
            mode_family = fam_immediate;
        end
        `EAG_MODE_PC_DISP, `EAG_MODE_PC_INDEX: begin
            mode_family = fam_pc_rel;
        end
        `EAG_MODE_IMPLIED: begin
            mode_family = fam_implied;
        end
        default: begin
            mode_family = fam_none;
        end
    endcase
end

// address generation for all modes
always @* begin
    next_err = 1'b0;
    next_mem = 1'b0;
    next_eff_addr = 32'h0000_0000;
    next_operand = 32'h0000_0000;
    next_wb_en = 1'b0;
    next_wb_value = 32'h0000_0000;
    case (MODE_I)
        `EAG_MODE_DREG: begin
            next_operand = DATA_REG_I;
        end
        `EAG_MODE_AREG: begin
            next_operand = ADDR_REG_I;
        end
        `EAG_MODE_IND: begin
            next_mem = 1'b1;
            next_eff_addr = ADDR_REG_I;
        end
        `EAG_MODE_POSTINC: begin
            next_mem = 1'b1;
            next_eff_addr = ADDR_REG_I;
            next_wb_en = 1'b1;
            next_wb_value = ADDR_REG_I + step;
        end
        `EAG_MODE_PREDEC: begin
            next_mem = 1'b1;
            next_eff_addr = ADDR_REG_I - step;
            next_wb_en = 1'b1;
            next_wb_value = ADDR_REG_I - step;
        end
        `EAG_MODE_DISP: begin
            next_mem = 1'b1;
            next_eff_addr = ADDR_REG_I + disp16;
        end
        `EAG_MODE_INDEX: begin
            next_mem = 1'b1;
            next_eff_addr = ADDR_REG_I + index_reg + disp8;
        end
        `EAG_MODE_ABS_SHORT: begin
            next_mem = 1'b1;
            next_eff_addr = abs_short;
        end
        `EAG_MODE_ABS_LONG: begin
            next_mem = 1'b1;
            next_eff_addr = abs_long;
        end
        `EAG_MODE_PC_DISP: begin
            next_mem = 1'b1;
            next_eff_addr = PROG_COUNTER_I + disp16;
        end
        `EAG_MODE_PC_INDEX: begin
            next_mem = 1'b1;
            next_eff_addr = PROG_COUNTER_I + index_reg + disp8;
        end
        `EAG_MODE_IMM: begin
            if (SIZE_I == `EAG_SIZE_LONG) begin
                next_operand = abs_long;
            end else if (SIZE_I == `EAG_SIZE_WORD) begin
                next_operand = {16'h0000, EXT0_I};
            end else begin
                next_operand = {24'h00_0000, EXT0_I[7:0]};
            end
        end
        `EAG_MODE_QUICK: begin
            next_operand = quick_val;
        end
        `EAG_MODE_IMPLIED: begin
            case (IMPL_SEL_I)
                `EAG_IMPL_STATUS: begin
                    next_operand = {16'h0000, STATUS_REG_I};
                end
                `EAG_IMPL_USP: begin
                    next_operand = USER_STACK_PTR_I;
                end
                `EAG_IMPL_SSP: begin
                    next_operand = SUPERVISOR_STACK_PTR_I;
                end
                default: begin
                    next_operand = PROG_COUNTER_I;
                end
            endcase
        end
        default: begin
            // codes above the fourteen modes are refused
            next_err = 1'b1;
        end
    endcase
    if (!size_ok || mode_family == fam_none) begin
        // a refused request must not touch the register file
        next_err = 1'b1;
        next_mem = 1'b0;
        next_wb_en = 1'b0;
    end
end

// byte lanes within the aligned long word touched by the access
always @* begin
    next_lanes = 4'h0;
    if (next_mem) begin
        case (SIZE_I)
            `EAG_SIZE_BYTE: begin
                case (next_eff_addr[1:0])
                    2'h0: next_lanes = 4'h8;
                    2'h1: next_lanes = 4'h4;
                    2'h2: next_lanes = 4'h2;
                    default: next_lanes = 4'h1;
                endcase
            end
            `EAG_SIZE_WORD: begin
                next_lanes = next_eff_addr[1] ? 4'h3 : 4'hC;
            end
            default: begin
                next_lanes = 4'hF;
            end
        endcase
    end
end

eag_alu u_alu (
    .op_i(ALU_OP_I),
    .a_i(ALU_A_I),
    .b_i(ALU_B_I),
    .extend_i(ALU_X_I),
    .res_o(alu_res),
    .trap_o(alu_trap)
);

// all results are held until the next request is taken
// strobes last one cycle per taken request
always @(posedge MCLK_I or negedge rst_sync) begin
    if (!rst_sync) begin
        DONE_O <= 1'b0;
        WB_EN_O <= 1'b0;
    end else begin
        DONE_O <= REQ_I;
        // write back strobe lasts one cycle with the operand result
        WB_EN_O <= REQ_I & next_wb_en;
    end
end

// operand location
always @(posedge MCLK_I or negedge rst_sync) begin
    if (!rst_sync) begin
        ERR_O <= 1'b0;
        MEM_ACCESS_O <= 1'b0;
        EFF_ADDR_O <= 32'h0000_0000;
        OPERAND_O <= 32'h0000_0000;
        BYTE_LANES_O <= 4'h0;
    end else if (REQ_I) begin
        ERR_O <= next_err;
        MEM_ACCESS_O <= next_mem;
        EFF_ADDR_O <= next_eff_addr;
        OPERAND_O <= next_operand;
        BYTE_LANES_O <= next_lanes;
    end
end

// register update handed to the register file
always @(posedge MCLK_I or negedge rst_sync) begin
    if (!rst_sync) begin
        WB_REG_O <= 3'h0;
        WB_VALUE_O <= 32'h0000_0000;
    end else if (REQ_I) begin
        WB_REG_O <= REG_SEL_I;
        WB_VALUE_O <= next_wb_value;
    end
end

// arithmetic result, held like the address outputs
always @(posedge MCLK_I or negedge rst_sync) begin
    if (!rst_sync) begin
        ALU_RESULT_O <= 32'h0000_0000;
        ALU_TRAP_O <= 1'b0;
    end else if (REQ_I) begin
        ALU_RESULT_O <= alu_res;
        ALU_TRAP_O <= alu_trap;
    end
end

endmodule // eag_core

//--- dv/eag_core_chk.sv
`timescale 1ns/10ps
module eag_core_chk (
    input wire MCLK_I,
    input wire RST_N_I,
    input wire REQ_I,
    input wire [3:0] MODE_I,
    input wire [1:0] SIZE_I,
    input wire [2:0] REG_SEL_I,
    input wire [31:0] DATA_REG_I,
    input wire [31:0] ADDR_REG_I,
    input wire [15:0] EXT0_I,
    input wire [31:0] PROG_COUNTER_I,
    input wire DONE_O,
    input wire ERR_O,
    input wire MEM_ACCESS_O,
    input wire [31:0] EFF_ADDR_O,
    input wire [31:0] OPERAND_O,
    input wire WB_EN_O,
    input wire [2:0] WB_REG_O,
    input wire [31:0] WB_VALUE_O
);
    // requests are ignored until the reset copy has passed its two flops
    reg [1:0] up;
    wire go = up[1] && REQ_I && SIZE_I != 2'h3;
    wire [31:0] step = SIZE_I == 2'h0 ? (REG_SEL_I == 3'h7 ? 32'h0000_0002 : 32'h0000_0001)
        : (SIZE_I == 2'h1 ? 32'h0000_0002 : 32'h0000_0004);
    // expected values are captured through $past of plain signals
    wire [31:0] inc_addr = ADDR_REG_I + step;
    wire [31:0] dec_addr = ADDR_REG_I - step;
    wire [31:0] direct_val = MODE_I[0] ? ADDR_REG_I : DATA_REG_I;
    wire [31:0] pc_disp = PROG_COUNTER_I + {{16{EXT0_I[15]}}, EXT0_I};
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I)
            up <= 2'h0;
        else if (!up[1])
            up <= up + 2'h1;
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    a_done_after_req: assert property (up[1] && REQ_I |=> DONE_O)
        else $error("no done after request");
    a_no_stray_done: assert property (up[1] && !REQ_I |=> !DONE_O && !WB_EN_O)
        else $error("done or writeback without request");
    a_postinc_step: assert property (go && MODE_I == 4'h3 |=>
        WB_EN_O && EFF_ADDR_O == $past(ADDR_REG_I) && WB_REG_O == $past(REG_SEL_I)
        && WB_VALUE_O == $past(inc_addr))
        else $error("postincrement wrong");
    a_predec_step: assert property (go && MODE_I == 4'h4 |=>
        WB_EN_O && EFF_ADDR_O == $past(dec_addr) && WB_VALUE_O == EFF_ADDR_O)
        else $error("predecrement wrong");
    a_direct_operand: assert property (go && MODE_I < 4'h2 |=>
        !MEM_ACCESS_O && OPERAND_O == $past(direct_val))
        else $error("register direct wrong");
    a_indirect_plain: assert property (go && MODE_I == 4'h2 |=>
        MEM_ACCESS_O && !WB_EN_O && EFF_ADDR_O == $past(ADDR_REG_I))
        else $error("indirect wrong");
    a_pc_disp: assert property (go && MODE_I == 4'h9 |=>
        EFF_ADDR_O == $past(pc_disp))
        else $error("pc displacement wrong");
    a_illegal_refused: assert property (
        up[1] && REQ_I && (MODE_I > 4'hD || SIZE_I == 2'h3)
        |=> ERR_O && DONE_O && !MEM_ACCESS_O && !WB_EN_O)
        else $error("illegal request not refused");
endmodule // eag_core_chk
bind eag_core eag_core_chk u_eag_core_chk (.MCLK_I, .RST_N_I, .REQ_I, .MODE_I, .SIZE_I,
    .REG_SEL_I, .DATA_REG_I, .ADDR_REG_I, .EXT0_I, .PROG_COUNTER_I, .DONE_O, .ERR_O,
    .MEM_ACCESS_O, .EFF_ADDR_O, .OPERAND_O, .WB_EN_O, .WB_REG_O, .WB_VALUE_O);

//--- dv/eag_regfile.sv
`timescale 1ns/10ps
module eag_regfile (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] sel_i,
    input wire logic wb_en_i,
    input wire logic [2:0] wb_reg_i,
    input wire logic [31:0] wb_value_i,
    output logic [31:0] addr_o
);
    logic [31:0] bank [8];
    assign addr_o = bank[sel_i];
    // writeback lands at the edge closing the done cycle; a request in that
    // cycle on the same register would still see the old value
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 8; i++)
                bank[i] <= 32'h0000_1000 | (i << 8);
        end else if (wb_en_i) begin
            bank[wb_reg_i] <= wb_value_i;
        end
    end
endmodule // eag_regfile

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench;
    typedef struct packed {logic [3:0] m; logic [1:0] s; logic [2:0] r;
        logic [3:0] ln; logic [31:0] v;} eag_row_t;
    logic MCLK_I = 0, RST_N_I = 0, REQ_I = 0, IDX_LONG_I = 1, ALU_X_I = 0;
    logic [3:0] MODE_I = 0;
    logic [1:0] SIZE_I = 0;
    logic [2:0] REG_SEL_I = 0, ALU_OP_I = 0;
    logic [7:0] QUICK_I = 8'h85;
    logic [15:0] EXT0_I = 16'hFFF0, EXT1_I = 16'h5678, STATUS_REG_I = 16'h2704;
    logic [31:0] ADDR_REG_I, ALU_A_I = 0, ALU_B_I = 0, IDX_ADDR_I = 32'h0001_0008;
    logic [31:0] DATA_REG_I = 32'h1111_2222, IDX_DATA_I = 32'h0000_0040;
    logic [31:0] PROG_COUNTER_I = 32'h0002_0000, USER_STACK_PTR_I = 32'h0000_3FFC;
    logic [31:0] SUPERVISOR_STACK_PTR_I = 32'h0000_7FF0;
    wire DONE_O, ERR_O, MEM_ACCESS_O, WB_EN_O, ALU_TRAP_O;
    wire [3:0] BYTE_LANES_O;
    wire [2:0] WB_REG_O;
    wire [31:0] EFF_ADDR_O, OPERAND_O, WB_VALUE_O, ALU_RESULT_O;
    int fails = 0, n_compared = 0, cycles = 0;
    // mode, size, register, byte lanes (0: no memory), address or operand
    eag_row_t rows [21] = '{'{4'h0, 2'h2, 3'h0, 4'h0, 32'h1111_2222},
        '{4'h1, 2'h1, 3'h2, 4'h0, 32'h0000_1200}, '{4'h2, 2'h2, 3'h2, 4'hF, 32'h0000_1200},
        '{4'h3, 2'h0, 3'h2, 4'h8, 32'h0000_1200}, '{4'h3, 2'h0, 3'h7, 4'h8, 32'h0000_1700},
        '{4'h4, 2'h1, 3'h3, 4'h3, 32'h0000_12FE}, '{4'h4, 2'h0, 3'h7, 4'h8, 32'h0000_1700},
        '{4'h5, 2'h1, 3'h3, 4'h3, 32'h0000_12EE}, '{4'h6, 2'h2, 3'h2, 4'hF, 32'h0001_11F9},
        '{4'h7, 2'h0, 3'h0, 4'h8, 32'hFFFF_FFF0}, '{4'h8, 2'h1, 3'h0, 4'hC, 32'hFFF0_5678},
        '{4'h9, 2'h1, 3'h0, 4'hC, 32'h0001_FFF0}, '{4'hA, 2'h0, 3'h0, 4'h8, 32'h0002_0030},
        '{4'hB, 2'h2, 3'h0, 4'h0, 32'hFFF0_5678}, '{4'hB, 2'h1, 3'h0, 4'h0, 32'h0000_FFF0},
        '{4'hB, 2'h0, 3'h0, 4'h0, 32'h0000_00F0}, '{4'hC, 2'h2, 3'h0, 4'h0, 32'hFFFF_FF85},
        '{4'hD, 2'h1, 3'h0, 4'h0, 32'h0000_2704}, '{4'hD, 2'h2, 3'h1, 4'h0, 32'h0000_3FFC},
        '{4'hD, 2'h2, 3'h2, 4'h0, 32'h0000_7FF0}, '{4'hD, 2'h2, 3'h3, 4'h0, 32'h0002_0000}};
    logic [31:0] aa [9] = '{32'h0001_0003, 32'h0000_FFFF, 32'h0000_0064, 32'hFFFF_FF9C,
        32'h0000_0045, 32'h0000_0045, 32'h0000_0100, 32'h0000_0100, 32'h0000_0064};
    logic [31:0] ab [9] = '{32'h0000_0005, 32'h0000_0002, 32'h0000_0007, 32'h0000_0007,
        32'h0000_0038, 32'h0000_0038, 32'h0000_0000, 32'h0000_0003, 32'h0000_0000};
    logic [31:0] ar [9] = '{32'h0000_000F, 32'hFFFF_FFFE, 32'h0002_000E, 32'hFFFE_FFF2,
        32'h0000_0084, 32'h0000_0007, 32'h0000_0108, 32'h0000_00FD, 32'h0000_0000};

    eag_core u_eag_core (.MCLK_I, .RST_N_I, .REQ_I, .MODE_I, .SIZE_I, .REG_SEL_I, .DATA_REG_I,
        .ADDR_REG_I, .IDX_DATA_I, .IDX_ADDR_I, .IDX_IS_ADDR_I(REG_SEL_I[1]), .IDX_LONG_I,
        .EXT0_I, .EXT1_I, .QUICK_I, .IMPL_SEL_I(REG_SEL_I[1:0]), .PROG_COUNTER_I,
        .STATUS_REG_I, .USER_STACK_PTR_I, .SUPERVISOR_STACK_PTR_I, .ALU_OP_I, .ALU_A_I,
        .ALU_B_I, .ALU_X_I, .DONE_O, .ERR_O, .MEM_ACCESS_O, .EFF_ADDR_O, .OPERAND_O,
        .BYTE_LANES_O, .WB_EN_O, .WB_REG_O, .WB_VALUE_O, .ALU_RESULT_O, .ALU_TRAP_O);
    eag_regfile u_eag_regfile (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .sel_i(REG_SEL_I),
        .wb_en_i(WB_EN_O), .wb_reg_i(WB_REG_O), .wb_value_i(WB_VALUE_O), .addr_o(ADDR_REG_I));

    always #25 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            fails++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // two cycles per request so the register file has taken any writeback
    task automatic req();
        @(negedge MCLK_I);
        REQ_I = 1;
        @(negedge MCLK_I);
        REQ_I = 0;
    endtask

    task results();
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge MCLK_I);
        chk({DONE_O, ERR_O, MEM_ACCESS_O, WB_EN_O, ALU_TRAP_O}, 0);
        chk(EFF_ADDR_O | OPERAND_O | ALU_RESULT_O, 0);
        RST_N_I = 1;
        repeat (2) @(negedge MCLK_I);
        for (int i = 0; i < 21; i++) begin
            MODE_I = rows[i].m;
            SIZE_I = rows[i].s;
            REG_SEL_I = rows[i].r;
            ALU_OP_I = i == 8 ? 3'h2 : i[2:0];
            ALU_A_I = aa[i % 9];
            ALU_B_I = ab[i % 9];
            ALU_X_I = i == 4;
            req();
            chk(DONE_O & !ERR_O, 1);
            chk(BYTE_LANES_O, rows[i].ln);
            chk(MEM_ACCESS_O, rows[i].ln != 0);
            chk(EFF_ADDR_O, rows[i].ln != 0 ? rows[i].v : 0);
            chk(OPERAND_O, rows[i].ln != 0 ? 0 : rows[i].v);
            chk(WB_EN_O, rows[i].m inside {4'h3, 4'h4});
            if (i < 9) begin
                chk(ALU_RESULT_O, ar[i]);
                chk(ALU_TRAP_O, i == 8);
            end
        end
        REG_SEL_I = 3'h3;
        #1 chk(ADDR_REG_I, 32'h0000_12FE);
        IDX_LONG_I = 0;
        MODE_I = 4'h6;
        SIZE_I = 2'h2;
        REG_SEL_I = 3'h2;
        req();
        chk(EFF_ADDR_O, 32'h0000_11F9);
        MODE_I = 4'hE;
        @(negedge MCLK_I);
        REQ_I = 1;
        @(negedge MCLK_I);
        chk({DONE_O, ERR_O, MEM_ACCESS_O, WB_EN_O}, 4'hC);
        MODE_I = 4'h0;
        SIZE_I = 2'h3;
        @(negedge MCLK_I);
        REQ_I = 0;
        chk({DONE_O, ERR_O, MEM_ACCESS_O, WB_EN_O}, 4'hC);
        RST_N_I = 0;
        #1 chk({DONE_O, ERR_O}, 0);
        results();
    end
endmodule // testbench
